// >>> pwm_irq_pkg.sv
// pwm event gathering and script pointer: shared constants
// assumes an 8-bit register port decoded by the serial slave logic upstream
package pwm_irq_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_RAW_STATUS    = 8'h7A;
    localparam logic [7:0] ADDR_MASKED_STATUS = 8'h7B;
    localparam logic [7:0] ADDR_EVENT_CLEAR   = 8'h7C;
    localparam logic [7:0] ADDR_WRITE_POINTER = 8'h7D;
    localparam logic [7:0] ADDR_SCRIPT_DATA   = 8'h7E;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int         NUM_TIMERS      = 3;
    localparam int         CYCLE_LSB       = 0;
    localparam int         PATTERN_LSB     = 3;
    localparam int         POINTER_WIDTH   = 7;
    localparam int         SLOTS_PER_TIMER = 32;
    localparam logic [5:0] STATUS_RESET    = 6'h00;
    localparam logic [6:0] POINTER_RESET   = 7'h00;
    localparam logic [6:0] POINTER_LIMIT   = 7'h60;

endpackage : pwm_irq_pkg

// >>> event_flag.sv
// one sticky event flag with write-one clear
// assumes event and clear pulses are synchronous to core_clk
module event_flag
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // event and clear
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    input  wire logic mask_en,
    // status
    output logic      raw,
    output logic      masked
);
    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t state;
    flag_state_t next_state;

    // set beats clear so a coinciding event is kept
    always_comb
    begin
        next_state = state;
        if (set_pulse)
            next_state.flag = 1'b1;
        else if (clear_pulse)
            next_state.flag = 1'b0;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            state <= '0;
        else if (clk_en)
            state <= next_state;
    end

    assign raw    = state.flag;
    assign masked = state.flag & mask_en;

    a_set_wins : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && set_pulse |=> raw)
        else $error("event lost against clear");
    a_clear_works : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && clear_pulse && !set_pulse |=> !raw && !masked)
        else $error("clear did not remove event");

endmodule : event_flag

// >>> pwm_event_irq.sv
// pwm event status, write-one clear and script write pointer
// assumes a byte register port from the serial slave; word_done marks the
// second byte of a script data word inside one write transaction
module pwm_event_irq
    import pwm_irq_pkg::*;
#(
    parameter int TIMERS = NUM_TIMERS
)
(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire logic                     clk_en,
    // register port
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    output logic      [7:0]               reg_rdata,
    // script data word completion from the slave
    input  wire logic                     word_done,
    // events from timers and pattern generators
    input  wire logic [TIMERS-1:0]        cycle_done_event,
    input  wire logic [TIMERS-1:0]        pattern_done_event,
    // mask configuration
    input  wire logic [TIMERS-1:0]        cycle_done_mask,
    input  wire logic [TIMERS-1:0]        pattern_done_mask,
    // outputs
    output logic                          irq,
    output logic [POINTER_WIDTH-1:0]      pwm_script_write_pointer,
    output logic [1:0]                    slot_timer,
    output logic                          slot_valid
);
    // the flag vector and register layout are fixed at three timers
    if (TIMERS != NUM_TIMERS)
    begin : g_bad_timers
        $error("timer count must be three for this register layout");
    end

    // ------------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------------
    logic       clear_hit;
    logic [5:0] set_vec;
    logic [5:0] clear_vec;
    logic [5:0] mask_vec;
    logic [5:0] pwm_raw_event_status;
    logic [5:0] pwm_masked_event_status;

    // clear is a pure strobe, nothing of it is stored
    assign clear_hit = reg_write && (reg_addr == ADDR_EVENT_CLEAR);
    assign clear_vec = clear_hit ? reg_wdata[5:0] : 6'h00;
    assign set_vec   = {pattern_done_event, cycle_done_event};
    assign mask_vec  = {pattern_done_mask, cycle_done_mask};

    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_flag
            event_flag u_flag
            (
                .core_clk    (core_clk),
                .reset       (reset),
                .clk_en      (clk_en),
                .set_pulse   (set_vec[g]),
                .clear_pulse (clear_vec[g]),
                .mask_en     (mask_vec[g]),
                .raw         (pwm_raw_event_status[g]),
                .masked      (pwm_masked_event_status[g])
            );
        end
    endgenerate

    // any masked bit reaches the request line
    assign irq = |pwm_masked_event_status;

    // ------------------------------------------------------------------
    // pointer and read data state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [POINTER_WIDTH-1:0] pointer;
        logic [7:0]               rdata;
    } core_state_t;

    core_state_t state;
    core_state_t next_state;

    always_comb
    begin
        next_state = state;
        // a pointer write wins over a word step in the same cycle
        if (reg_write && reg_addr == ADDR_WRITE_POINTER)
            next_state.pointer = reg_wdata[POINTER_WIDTH-1:0];
        else if (word_done)
            next_state.pointer = state.pointer + 7'h01;
        // read data registered; unmapped reads give zero
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_RAW_STATUS:    next_state.rdata = {2'b00, pwm_raw_event_status};
                ADDR_MASKED_STATUS: next_state.rdata = {2'b00, pwm_masked_event_status};
                ADDR_WRITE_POINTER: next_state.rdata = {1'b0, state.pointer};
                default:            next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            state <= '{pointer: POINTER_RESET, rdata: 8'h00};
        else if (clk_en)
            state <= next_state;
    end

    assign reg_rdata                = state.rdata;
    assign pwm_script_write_pointer = state.pointer;

    // slot decode; pointer values 96 and up select nothing
    always_comb
    begin
        slot_valid = state.pointer < POINTER_LIMIT;
        slot_timer = 2'(state.pointer / SLOTS_PER_TIMER);
        if (!slot_valid)
            slot_timer = 2'h3;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_irq_follows : assert property (@(posedge core_clk) disable iff (reset)
        irq == (pwm_masked_event_status != 6'h00))
        else $error("request line disagrees with masked status");
    a_mask_gates : assert property (@(posedge core_clk) disable iff (reset)
        pwm_masked_event_status == (pwm_raw_event_status & mask_vec))
        else $error("masked status not raw gated by mask");
    // read-back of the masked bits, with the mask both open and closed
    a_cyc1_raise : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && reg_read && reg_addr == ADDR_MASKED_STATUS && pwm_raw_event_status[1] && cycle_done_mask[1]
        |=> reg_rdata[1])
        else $error("timer 1 cycle event missing in masked status");
    a_cyc1_masked : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && reg_read && reg_addr == ADDR_MASKED_STATUS && pwm_raw_event_status[1] && !cycle_done_mask[1]
        |=> !reg_rdata[1])
        else $error("masked-off timer 1 cycle event still reported");
    a_cyc0_read : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && reg_read && reg_addr == ADDR_MASKED_STATUS && pwm_raw_event_status[0] && cycle_done_mask[0]
        |=> reg_rdata[0])
        else $error("timer 0 cycle event missing in masked status");
    a_clear_zero_noop : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && clear_hit && !reg_wdata[0] && pwm_raw_event_status[0] |=> pwm_raw_event_status[0])
        else $error("writing zero cleared an event");
    a_pattern_clear : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && clear_hit && reg_wdata[5] && !pattern_done_event[2] |=> !pwm_raw_event_status[5])
        else $error("bit 5 did not clear timer 2 pattern event");
    a_ptr_step : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && word_done && !(reg_write && reg_addr == ADDR_WRITE_POINTER)
        |=> pwm_script_write_pointer == $past(pwm_script_write_pointer) + 7'h01)
        else $error("pointer did not step after script word");
    a_ptr_hold : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && !word_done && !(reg_write && reg_addr == ADDR_WRITE_POINTER)
        |=> $stable(pwm_script_write_pointer))
        else $error("pointer moved without a full word");
    a_slot_map : assert property (@(posedge core_clk) disable iff (reset)
        pwm_script_write_pointer inside {[7'd32:7'd63]} |-> slot_valid && slot_timer == 2'h1)
        else $error("pointer slot map wrong");
    a_cyc0_reset : assert property (@(posedge core_clk)
        $fell(reset) |-> pwm_masked_event_status[0] == 1'b0)
        else $error("timer 0 cycle status not zero after reset");
    // the request line must come out of reset quiet as well
    a_irq_reset : assert property (@(posedge core_clk)
        $fell(reset) |-> !irq)
        else $error("request line high after reset");

    // ------------------------------------------------------------------
    // event capture and clear checks
    // ------------------------------------------------------------------
    // a timer pulse must land in its own flag position, not a neighbour's
    a_cyc_raise : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && cycle_done_event[2] |=> pwm_raw_event_status[2])
        else $error("timer 2 cycle event not captured");
    a_pat_raise : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && pattern_done_event[0] |=> pwm_raw_event_status[3])
        else $error("timer 0 pattern event not captured");
    a_cyc_clear : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && clear_hit && reg_wdata[1] && !cycle_done_event[1] |=> !pwm_raw_event_status[1])
        else $error("bit 1 did not clear timer 1 cycle event");
    // with no clear and no event the flags hold, so no clear state lingers
    a_clear_strobe : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && !clear_hit && set_vec == 6'h00 |=> $stable(pwm_raw_event_status))
        else $error("event flags moved without event or clear");

    // ------------------------------------------------------------------
    // pointer load and read-back checks
    // ------------------------------------------------------------------
    // the pointer keeps seven bits; bit 7 of a write is dropped
    a_ptr_load : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && reg_write && reg_addr == ADDR_WRITE_POINTER
        |=> {1'b0, pwm_script_write_pointer} == ($past(reg_wdata) & 8'h7F))
        else $error("pointer write did not load the low seven bits");
    a_ptr_read : assert property (@(posedge core_clk) disable iff (reset)
        clk_en && reg_read && reg_addr == ADDR_WRITE_POINTER
        |=> reg_rdata == {1'b0, $past(pwm_script_write_pointer)})
        else $error("pointer read-back wrong");

endmodule : pwm_event_irq

// >>> host_port_model.sv
// host side of the register port: byte writes, reads and two-byte script words
// assumes strobes are taken on the rising core_clk edge after they are raised
module host_port_model
    import pwm_irq_pkg::*;
(
    // clock
    input  wire logic       core_clk,
    // register port toward the design
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_write,
    output logic            reg_read,
    output logic            word_done
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    initial
    begin
        {reg_addr, reg_wdata} = 16'h0000;
        {reg_write, reg_read, word_done} = 3'h0;
    end

    // released address and data show the inverse, so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic wd);
        @(posedge core_clk) #1;
        {reg_addr, reg_wdata, reg_write, word_done} = {a, d, 1'b1, wd};
        @(posedge core_clk) #1;
        {reg_addr, reg_wdata, reg_write, word_done} = {~a, ~d, 1'b0, 1'b0};
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk) #1;
        {reg_addr, reg_read} = {a, 1'b1};
        @(posedge core_clk) #1;
        {reg_addr, reg_read} = {~a, 1'b0};
        v = reg_rdata;
    endtask : read_reg

    // a script word is two bytes in one transaction, counted on the second
    task automatic send_word(input logic [15:0] w);
        write_reg(ADDR_SCRIPT_DATA, w[7:0], 1'b0);
        write_reg(ADDR_SCRIPT_DATA, w[15:8], 1'b1);
    endtask : send_word
endmodule : host_port_model

// >>> tb.sv
// self-checking bench for the pwm event gathering and script pointer block
// assumes the host model drives the register port one cycle per strobe
module tb
    import pwm_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk, reset, clk_en, reg_write, reg_read, word_done, irq, slot_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] cyc, pat, cmask, pmask;
    logic [6:0] ptr;
    logic [1:0] slot_timer;
    int         error_cnt, checks_done;

    pwm_event_irq DUT (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .word_done(word_done), .cycle_done_event(cyc), .pattern_done_event(pat),
        .cycle_done_mask(cmask), .pattern_done_mask(pmask), .irq(irq),
        .pwm_script_write_pointer(ptr), .slot_timer(slot_timer), .slot_valid(slot_valid));
    host_port_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .word_done(word_done));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.read_reg(a, v);
        chk(v, exp);
    endtask : rd

    // one-cycle event pulses from the timers and pattern generators
    task automatic ev(input logic [2:0] c, input logic [2:0] p);
        @(posedge core_clk) #1;
        {cyc, pat} = {c, p};
        @(posedge core_clk) #1;
        {cyc, pat} = 6'h00;
    endtask : ev

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // watchdog: the sequence needs a little over a hundred cycles
    initial
    begin
        #(100 * 5000);
        error_cnt++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {reset, clk_en, cyc, pat, cmask, pmask} = {2'b11, 12'h03F};
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        rd(ADDR_MASKED_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        ev(3'h3, 3'h4);
        rd(ADDR_MASKED_STATUS, 8'h23);
        chk({7'h00, irq}, 8'h01);
        cmask = 3'h5;
        rd(ADDR_MASKED_STATUS, 8'h21);
        rd(ADDR_RAW_STATUS, 8'h23);
        cmask = 3'h7;
        // each clear bit alone, with the reserved bits set and ignored
        for (int i = 0; i < 6; i++)
        begin
            ev(3'h7, 3'h7);
            host.write_reg(ADDR_EVENT_CLEAR, 8'hC0 | (8'h01 << i), 1'b0);
            rd(ADDR_MASKED_STATUS, 8'h3F ^ (8'h01 << i));
        end
        host.write_reg(ADDR_EVENT_CLEAR, 8'h00, 1'b0);
        rd(ADDR_RAW_STATUS, 8'h1F);
        host.write_reg(ADDR_EVENT_CLEAR, 8'h3F, 1'b0);
        rd(ADDR_RAW_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rd(ADDR_EVENT_CLEAR, 8'h00);
        fork
            host.write_reg(ADDR_EVENT_CLEAR, 8'h01, 1'b0);
            ev(3'h1, 3'h0);
        join
        rd(ADDR_RAW_STATUS, 8'h01);
        // a low clock enable must swallow the event
        clk_en = 1'b0;
        ev(3'h2, 3'h0);
        clk_en = 1'b1;
        rd(ADDR_RAW_STATUS, 8'h01);
        host.write_reg(ADDR_WRITE_POINTER, 8'h1F, 1'b0);
        rd(ADDR_WRITE_POINTER, 8'h1F);
        host.write_reg(ADDR_SCRIPT_DATA, 8'hA5, 1'b0);
        rd(ADDR_WRITE_POINTER, 8'h1F);
        host.send_word(16'h1234);
        rd(ADDR_WRITE_POINTER, 8'h20);
        chk({1'b0, ptr}, 8'h20);
        // slot decoding at the first and last slot of each timer block
        for (int k = 0; k < 4; k++)
        begin
            host.write_reg(ADDR_WRITE_POINTER, 8'(k * 32), 1'b0);
            chk({1'b0, ptr}, 8'(k * 32));
            chk({6'h00, slot_timer}, 8'(k));
            chk({7'h00, slot_valid}, 8'(k < 3));
            host.write_reg(ADDR_WRITE_POINTER, 8'(k * 32 + 31), 1'b0);
            chk({6'h00, slot_timer}, 8'(k));
            chk({7'h00, slot_valid}, 8'(k < 3));
        end
        // the pointer wraps from the last invalid slot back to zero
        host.send_word(16'h5678);
        chk({1'b0, ptr}, 8'h00);
        // a pointer write beats a word step in the same cycle; bit 7 is dropped
        host.write_reg(ADDR_WRITE_POINTER, 8'h85, 1'b1);
        rd(ADDR_WRITE_POINTER, 8'h05);
        // reset in mid-run with an event pending and the pointer away from zero
        ev(3'h4, 3'h0);
        chk({7'h00, irq}, 8'h01);
        @(posedge core_clk) #1;
        reset = 1'b1;
        @(posedge core_clk) #1;
        reset = 1'b0;
        chk({1'b0, ptr}, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rd(ADDR_MASKED_STATUS, 8'h00);
        rd(ADDR_RAW_STATUS, 8'h00);
        end_sim();
    end
endmodule : tb
